// *** dlmc_device.sv ***
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module dlmc_device (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  dlmc_link_if.dev link,
  output logic [5:0] o_read_latency,
  output logic [5:0] o_write_latency,
  output logic [5:0] o_rtp_cycles,
  output logic [5:0] o_wrec_cycles,
  output logic o_write_leveling,
  output logic o_busy,
  output logic o_beat_valid,
  output logic o_beat_write,
  output logic [4:0] o_beat_index,
  output logic o_precharge
);
  logic [7:0] lat_reg [0:1];
  logic inv_reg [0:1];
  logic [2:0] wrec_reg [0:1];
  logic sp_wr_reg;
  logic sp_op_reg;
  logic wl_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_data_reg;
  dlmc_pkg::dlmc_state_t state_reg;
  logic [5:0] cnt_reg;
  logic is_wr_reg;
  logic bl32_reg;
  logic ap_reg;
  logic [4:0] beat_reg;
  logic beat_valid_reg;
  logic pre_reg;
  logic [5:0] rl_reg;
  logic [5:0] wlat_reg;
  logic [5:0] rtp_reg;
  logic [5:0] wrec_cyc_reg;
  logic [7:0] act_lat;
  logic take;
  logic is_mrw;
  logic lvl_clear;

  assign is_mrw = link.cmd_valid && (link.cmd_kind == dlmc_pkg::DLMC_MRW);
  assign lvl_clear = is_mrw && (link.cmd_ma == dlmc_pkg::MA_LAT);
  assign take = link.cmd_valid && (!wl_reg || lvl_clear);
  assign act_lat = lat_reg[sp_op_reg];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lat_reg[0] <= dlmc_pkg::LAT_RESET;
      lat_reg[1] <= dlmc_pkg::LAT_RESET;
      inv_reg[0] <= 1'b0;
      inv_reg[1] <= 1'b0;
      wrec_reg[0] <= 3'h0;
      wrec_reg[1] <= 3'h0;
    end else if (take && is_mrw) begin
      unique case (link.cmd_ma)
        dlmc_pkg::MA_LAT: lat_reg[sp_wr_reg] <= link.cmd_op;
        dlmc_pkg::MA_IO: inv_reg[sp_wr_reg] <= link.cmd_op[dlmc_pkg::INV_BIT];
        dlmc_pkg::MA_WREC: wrec_reg[sp_wr_reg] <= link.cmd_op[dlmc_pkg::WREC_LSB +: 3];
        default: ;
      endcase
    end
  end

  // set point control is a single copy
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sp_wr_reg <= 1'b0;
      sp_op_reg <= 1'b0;
    end else if (take && is_mrw && link.cmd_ma == dlmc_pkg::MA_SP) begin
      sp_wr_reg <= link.cmd_op[dlmc_pkg::SP_WR_BIT];
      sp_op_reg <= link.cmd_op[dlmc_pkg::SP_OP_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wl_reg <= 1'b0;
    end else if (take && lvl_clear) begin
      wl_reg <= link.cmd_op[dlmc_pkg::LEVEL_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      rsp_valid_reg <= take && link.cmd_kind == dlmc_pkg::DLMC_MRR;
      if (take && link.cmd_kind == dlmc_pkg::DLMC_MRR) begin
        unique case (link.cmd_ma)
          dlmc_pkg::MA_LAT: rsp_data_reg <= lat_reg[sp_wr_reg];
          dlmc_pkg::MA_IO: rsp_data_reg <= {1'b0, inv_reg[sp_wr_reg], 6'h00};
          dlmc_pkg::MA_WREC: rsp_data_reg <= {1'b0, wrec_reg[sp_wr_reg], 4'h0};
          dlmc_pkg::MA_SP: rsp_data_reg <= {sp_op_reg, sp_wr_reg, 6'h00};
          default: rsp_data_reg <= 8'h00;
        endcase
      end
    end
  end

  // timings follow the active copy every cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rl_reg <= 6'h06;
      wlat_reg <= 6'h04;
      rtp_reg <= 6'h08;
      wrec_cyc_reg <= 6'h06;
    end else begin
      rl_reg <= dlmc_pkg::dlmc_read_lat(act_lat[dlmc_pkg::RD_CODE_LSB +: 3],
                                        inv_reg[sp_op_reg]);
      wlat_reg <= dlmc_pkg::dlmc_write_lat(act_lat[dlmc_pkg::WR_CODE_LSB +: 3],
                                           act_lat[dlmc_pkg::TABLE_SEL_BIT]);
      rtp_reg <= dlmc_pkg::dlmc_rtp(act_lat[dlmc_pkg::RD_CODE_LSB +: 3]);
      wrec_cyc_reg <= dlmc_pkg::dlmc_wrec(wrec_reg[sp_op_reg]);
    end
  end

  // bursts run one at a time; read and write commands arriving while busy are dropped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= dlmc_pkg::DLMC_IDLE;
      cnt_reg <= 6'h00;
      is_wr_reg <= 1'b0;
      bl32_reg <= 1'b0;
      ap_reg <= 1'b0;
      beat_reg <= 5'h00;
      beat_valid_reg <= 1'b0;
      pre_reg <= 1'b0;
    end else begin
      pre_reg <= 1'b0;
      beat_valid_reg <= 1'b0;
      unique case (state_reg)
        dlmc_pkg::DLMC_IDLE: begin
          if (take && (link.cmd_kind == dlmc_pkg::DLMC_WRITE ||
                       link.cmd_kind == dlmc_pkg::DLMC_READ)) begin
            is_wr_reg <= link.cmd_kind == dlmc_pkg::DLMC_WRITE;
            bl32_reg <= link.cmd_bl32;
            ap_reg <= link.cmd_ap;
            cnt_reg <= (link.cmd_kind == dlmc_pkg::DLMC_WRITE ? wlat_reg : rl_reg) - 6'h01;
            state_reg <= dlmc_pkg::DLMC_LAT;
          end
        end
        dlmc_pkg::DLMC_LAT: begin
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            beat_reg <= 5'h00;
            beat_valid_reg <= 1'b1;
            state_reg <= dlmc_pkg::DLMC_BURST;
          end
        end
        dlmc_pkg::DLMC_BURST: begin
          if (beat_reg == (bl32_reg ? dlmc_pkg::BEATS_32 : dlmc_pkg::BEATS_16)) begin
            if (ap_reg) begin
              cnt_reg <= is_wr_reg ? wrec_cyc_reg :
                         rtp_reg + (bl32_reg ? dlmc_pkg::LONG_BURST_EXTRA : 6'h00);
              state_reg <= dlmc_pkg::DLMC_RECOV;
            end else begin
              state_reg <= dlmc_pkg::DLMC_IDLE;
            end
          end else begin
            beat_reg <= beat_reg + 5'h01;
            beat_valid_reg <= 1'b1;
          end
        end
        dlmc_pkg::DLMC_RECOV: begin
          cnt_reg <= cnt_reg - 6'h01;
          if (cnt_reg == 6'h01) begin
            pre_reg <= 1'b1;
            state_reg <= dlmc_pkg::DLMC_IDLE;
          end
        end
      endcase
    end
  end

  logic busy_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= state_reg != dlmc_pkg::DLMC_IDLE;
    end
  end

  assign link.rsp_valid = rsp_valid_reg;
  assign link.rsp_data = rsp_data_reg;
  assign o_read_latency = rl_reg;
  assign o_write_latency = wlat_reg;
  assign o_rtp_cycles = rtp_reg;
  assign o_wrec_cycles = wrec_cyc_reg;
  assign o_write_leveling = wl_reg;
  assign o_busy = busy_reg;
  assign o_beat_valid = beat_valid_reg;
  assign o_beat_write = is_wr_reg;
  assign o_beat_index = beat_reg;
  assign o_precharge = pre_reg;
endmodule : dlmc_device

// *** dlmc_host.sv ***
`timescale 1ns/1ps
module dlmc_host (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  dlmc_link_if.ctrl link,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  logic cmd_valid_reg;
  dlmc_pkg::dlmc_cmd_t kind_reg;
  logic [5:0] ma_reg;
  logic [7:0] op_reg;
  logic [7:0] col_reg;
  logic bl32_reg;
  logic ap_reg;
  logic [11:0] freq_reg;
  logic lvl_reg;
  logic refused_reg;
  logic [7:0] mrr_reg;
  logic mrr_new_reg;
  logic [31:0] rdata_reg;
  logic cmd_wr;
  logic allowed;
  dlmc_pkg::dlmc_cmd_t new_kind;
  logic [2:0] band;

  assign cmd_wr = i_wr && i_addr == dlmc_pkg::OFF_CMD;
  assign new_kind = dlmc_pkg::dlmc_cmd_t'(i_wdata[15:14]);
  assign allowed = !lvl_reg || (new_kind == dlmc_pkg::DLMC_MRW &&
                   i_wdata[13:8] == dlmc_pkg::MA_LAT && !i_wdata[dlmc_pkg::LEVEL_BIT]);
  assign band = dlmc_pkg::dlmc_band(freq_reg);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cmd_valid_reg <= 1'b0;
      kind_reg <= dlmc_pkg::DLMC_MRW;
      ma_reg <= 6'h00;
      op_reg <= 8'h00;
      col_reg <= 8'h00;
      bl32_reg <= 1'b0;
      ap_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= cmd_wr && allowed;
      if (cmd_wr && allowed) begin
        kind_reg <= new_kind;
        ma_reg <= i_wdata[13:8];
        op_reg <= i_wdata[7:0];
        bl32_reg <= i_wdata[16];
        ap_reg <= i_wdata[17];
        col_reg <= i_wdata[7:0];
        if (new_kind == dlmc_pkg::DLMC_WRITE) begin
          col_reg <= {i_wdata[7:3], i_wdata[2] && !i_wdata[16], 2'h0};
        end
      end
    end
  end

  // shadow of the leveling bit, so commands can be held back locally
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lvl_reg <= 1'b0;
    end else if (cmd_wr && allowed && new_kind == dlmc_pkg::DLMC_MRW &&
                 i_wdata[13:8] == dlmc_pkg::MA_LAT) begin
      lvl_reg <= i_wdata[dlmc_pkg::LEVEL_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      freq_reg <= dlmc_pkg::FREQ_RESET;
    end else if (i_wr && i_addr == dlmc_pkg::OFF_FREQ) begin
      freq_reg <= i_wdata[11:0];
    end
  end

  // set wins over the clear by status write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      refused_reg <= 1'b0;
    end else if (cmd_wr && !allowed) begin
      refused_reg <= 1'b1;
    end else if (i_wr && i_addr == dlmc_pkg::OFF_STAT) begin
      refused_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mrr_reg <= 8'h00;
      mrr_new_reg <= 1'b0;
    end else if (link.rsp_valid) begin
      mrr_reg <= link.rsp_data;
      mrr_new_reg <= 1'b1;
    end else if (i_rd && i_addr == dlmc_pkg::OFF_RDATA) begin
      mrr_new_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (i_rd) begin
      unique case (i_addr)
        dlmc_pkg::OFF_FREQ: rdata_reg <= {20'h00000, freq_reg};
        dlmc_pkg::OFF_STAT: rdata_reg <= {18'h00000, dlmc_pkg::dlmc_wrec(band), 2'h0,
                                          mrr_new_reg, refused_reg, lvl_reg, band};
        dlmc_pkg::OFF_RDATA: rdata_reg <= {24'h000000, mrr_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign link.cmd_valid = cmd_valid_reg;
  assign link.cmd_kind = kind_reg;
  assign link.cmd_ma = ma_reg;
  assign link.cmd_op = op_reg;
  assign link.cmd_col = col_reg;
  assign link.cmd_bl32 = bl32_reg;
  assign link.cmd_ap = ap_reg;
  assign o_rdata = rdata_reg;
endmodule : dlmc_host

// *** dlmc_link_asserts.sv ***
`timescale 1ns/1ps
module dlmc_link_asserts (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic cmd_valid,
  input wire dlmc_pkg::dlmc_cmd_t cmd_kind,
  input wire logic [5:0] cmd_ma,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_col,
  input wire logic cmd_bl32,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data
);
  logic lvl_reg;
  logic sp_reg;
  logic rd_lat_reg;
  logic [7:0] copy0_reg;
  logic [7:0] copy1_reg;
  logic [7:0] exp_reg;
  wire mode_register_write_cmd = cmd_valid && cmd_kind == dlmc_pkg::DLMC_MRW;
  wire mode_register_read_cmd = cmd_valid && cmd_kind == dlmc_pkg::DLMC_MRR;
  wire wrb = cmd_valid && cmd_kind == dlmc_pkg::DLMC_WRITE;
  wire to_lat = cmd_ma == dlmc_pkg::MA_LAT;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // leveling follows the last latency write, whichever copy it lands in
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) lvl_reg <= 1'b0;
    else if (mode_register_write_cmd && to_lat) lvl_reg <= cmd_op[dlmc_pkg::LEVEL_BIT];
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) sp_reg <= 1'b0;
    else if (mode_register_write_cmd && cmd_ma == dlmc_pkg::MA_SP) sp_reg <= cmd_op[dlmc_pkg::SP_WR_BIT];
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      copy0_reg <= 8'h00;
      copy1_reg <= 8'h00;
    end else if (mode_register_write_cmd && to_lat && !sp_reg) copy0_reg <= cmd_op;
    else if (mode_register_write_cmd && to_lat) copy1_reg <= cmd_op;
  end
  // expected readback is frozen at the edge that takes the read
  always_ff @(posedge i_clk) begin
    rd_lat_reg <= !i_sys_rst && mode_register_read_cmd && to_lat;
    exp_reg <= sp_reg ? copy1_reg : copy0_reg;
  end
  chk_write_col_zero: assert property (wrb |-> cmd_col[1:0] == 2'h0)
    else $error("write column bits not zero");
  chk_long_align: assert property (wrb && cmd_bl32 |-> !cmd_col[2])
    else $error("long write not aligned");
  chk_rsp_follows: assert property (mode_register_read_cmd |=> rsp_valid)
    else $error("mode read unanswered");
  chk_rsp_cause: assert property (rsp_valid |-> $past(mode_register_read_cmd))
    else $error("response without read");
  chk_rsp_copy: assert property (rsp_valid && rd_lat_reg |-> rsp_data == exp_reg)
    else $error("readback from wrong copy");
  chk_level_only_lat: assert property (lvl_reg && cmd_valid |-> mode_register_write_cmd && to_lat)
    else $error("command during leveling");
  chk_level_clears: assert property (lvl_reg && mode_register_write_cmd |-> !cmd_op[7])
    else $error("leveling write does not clear");
  chk_level_silent: assert property (lvl_reg ##1 lvl_reg |-> !rsp_valid)
    else $error("response during leveling");
endmodule : dlmc_link_asserts

// *** dlmc_link_if.sv ***
`timescale 1ns/1ps
interface dlmc_link_if;
  logic cmd_valid;
  dlmc_pkg::dlmc_cmd_t cmd_kind;
  logic [5:0] cmd_ma;
  logic [7:0] cmd_op;
  // column C9..C2; the two lowest bits are implied zero
  logic [7:0] cmd_col;
  logic cmd_bl32;
  logic cmd_ap;
  logic rsp_valid;
  logic [7:0] rsp_data;

  modport dev (
    input cmd_valid, cmd_kind, cmd_ma, cmd_op, cmd_col, cmd_bl32, cmd_ap,
    output rsp_valid, rsp_data
  );
  modport ctrl (
    output cmd_valid, cmd_kind, cmd_ma, cmd_op, cmd_col, cmd_bl32, cmd_ap,
    input rsp_valid, rsp_data
  );
endinterface : dlmc_link_if

// *** dlmc_pkg.sv ***
// Operation
// - column bits zero and one never sent
// - controller zeroes column bits two, three on writes
// - write start aligned to burst size
// - write beats run sequentially from zero
// - read code maps latency, precharge delay
// - inversion on uses second read mapping
// - table zero maps write latency set one
// - table one maps write latency set two
// - bit six selects write table
// - bit seven holds write leveling state
// - only clearing write allowed while leveling
// - commands reach write-selected set point copy
// - device runs from active set point copy
// - codes must match clock frequency band; not checked, the host only reports the band in status
// - long read bursts add eight precharge clocks
// - inversion bit picks read mapping
// - write recovery delays auto precharge
package dlmc_pkg;
  localparam logic [5:0] MA_WREC = 6'h01;
  localparam logic [5:0] MA_LAT = 6'h02;
  localparam logic [5:0] MA_IO = 6'h03;
  localparam logic [5:0] MA_SP = 6'h0D;
  localparam int RD_CODE_LSB = 0;
  localparam int WR_CODE_LSB = 3;
  localparam int TABLE_SEL_BIT = 6;
  localparam int LEVEL_BIT = 7;
  localparam int INV_BIT = 6;
  localparam int WREC_LSB = 4;
  localparam int SP_WR_BIT = 6;
  localparam int SP_OP_BIT = 7;
  localparam logic [7:0] LAT_RESET = 8'h00;
  localparam logic [4:0] BEATS_16 = 5'h0F;
  localparam logic [4:0] BEATS_32 = 5'h1F;
  localparam logic [5:0] LONG_BURST_EXTRA = 6'h08;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_FREQ = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0C;
  localparam logic [11:0] FREQ_RESET = 12'h10A;

  typedef enum logic [1:0] {
    DLMC_MRW = 2'h0,
    DLMC_MRR = 2'h1,
    DLMC_WRITE = 2'h2,
    DLMC_READ = 2'h3
  } dlmc_cmd_t;

  typedef enum logic [1:0] {
    DLMC_IDLE = 2'h0,
    DLMC_LAT = 2'h1,
    DLMC_BURST = 2'h3,
    DLMC_RECOV = 2'h2
  } dlmc_state_t;

  function automatic logic [5:0] dlmc_read_lat(input logic [2:0] code, input logic inv);
    logic [5:0] r;
    r = 6'h06;
    unique case (code)
      3'h0: r = 6'h06;
      3'h1: r = inv ? 6'h0C : 6'h0A;
      3'h2: r = inv ? 6'h10 : 6'h0E;
      3'h3: r = inv ? 6'h16 : 6'h14;
      3'h4: r = inv ? 6'h1C : 6'h18;
      3'h5: r = inv ? 6'h20 : 6'h1C;
      3'h6: r = inv ? 6'h24 : 6'h20;
      3'h7: r = inv ? 6'h28 : 6'h24;
    endcase
    return r;
  endfunction : dlmc_read_lat

  function automatic logic [5:0] dlmc_write_lat(input logic [2:0] code, input logic sel);
    logic [5:0] r;
    r = 6'h04;
    unique case (code)
      3'h0: r = 6'h04;
      3'h1: r = sel ? 6'h08 : 6'h06;
      3'h2: r = sel ? 6'h0C : 6'h08;
      3'h3: r = sel ? 6'h12 : 6'h0A;
      3'h4: r = sel ? 6'h16 : 6'h0C;
      3'h5: r = sel ? 6'h1A : 6'h0E;
      3'h6: r = sel ? 6'h1E : 6'h10;
      3'h7: r = sel ? 6'h22 : 6'h12;
    endcase
    return r;
  endfunction : dlmc_write_lat

  function automatic logic [5:0] dlmc_rtp(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h08;
    if (code[2]) begin
      r = {3'h0, code[1:0], 1'b0} + 6'h0A;
    end
    return r;
  endfunction : dlmc_rtp

  function automatic logic [5:0] dlmc_wrec(input logic [2:0] code);
    logic [5:0] r;
    r = 6'h06;
    unique case (code)
      3'h0: r = 6'h06;
      3'h1: r = 6'h0A;
      3'h2: r = 6'h10;
      3'h3: r = 6'h14;
      3'h4: r = 6'h18;
      3'h5: r = 6'h1E;
      3'h6: r = 6'h22;
      3'h7: r = 6'h28;
    endcase
    return r;
  endfunction : dlmc_wrec

  // band index 0..7; lower edge exclusive, upper inclusive
  function automatic logic [2:0] dlmc_band(input logic [11:0] mhz);
    logic [2:0] b;
    b = 3'h7;
    if (mhz <= 12'h10A) b = 3'h0;
    else if (mhz <= 12'h215) b = 3'h1;
    else if (mhz <= 12'h320) b = 3'h2;
    else if (mhz <= 12'h42A) b = 3'h3;
    else if (mhz <= 12'h535) b = 3'h4;
    else if (mhz <= 12'h640) b = 3'h5;
    else if (mhz <= 12'h74A) b = 3'h6;
    return b;
  endfunction : dlmc_band
endpackage : dlmc_pkg

// *** dram_latency_mode_config_test.sv ***
`timescale 1ns/1ps
module dram_latency_mode_config_test;
  localparam logic [7:0] RA [8] = '{8'h06, 8'h0A, 8'h0E, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
  localparam logic [7:0] RB [8] = '{8'h06, 8'h0C, 8'h10, 8'h16, 8'h1C, 8'h20, 8'h24, 8'h28};
  localparam logic [7:0] RTP [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10};
  localparam logic [7:0] WA [8] = '{8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h10, 8'h12};
  localparam logic [7:0] WB [8] = '{8'h04, 8'h08, 8'h0C, 8'h12, 8'h16, 8'h1A, 8'h1E, 8'h22};
  localparam logic [7:0] WRITE_RECOVERY_CYCLES [8] = '{8'h06, 8'h0A, 8'h10, 8'h14, 8'h18, 8'h1E, 8'h22, 8'h28};
  localparam logic [11:0] TOP [8] = '{12'h10A, 12'h215, 12'h320, 12'h42A, 12'h535, 12'h640,
                                      12'h74A, 12'h855};
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [31:0] d;
  logic [5:0] o_read_latency, o_write_latency, o_rtp_cycles, o_wrec_cycles;
  logic o_write_leveling, o_busy, o_beat_valid, o_beat_write, o_precharge;
  logic [4:0] o_beat_index;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  dlmc_link_if link();
  dlmc_host u_dlmc_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  dlmc_device u_dlmc_device (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link),
    .o_read_latency(o_read_latency), .o_write_latency(o_write_latency),
    .o_rtp_cycles(o_rtp_cycles), .o_wrec_cycles(o_wrec_cycles),
    .o_write_leveling(o_write_leveling), .o_busy(o_busy), .o_beat_valid(o_beat_valid),
    .o_beat_write(o_beat_write), .o_beat_index(o_beat_index), .o_precharge(o_precharge));
  dlmc_link_asserts u_dlmc_link_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .cmd_valid(link.cmd_valid), .cmd_kind(link.cmd_kind), .cmd_ma(link.cmd_ma),
    .cmd_op(link.cmd_op), .cmd_col(link.cmd_col), .cmd_bl32(link.cmd_bl32),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  // the whole run needs about 500 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd
  task automatic cmd(input logic [1:0] k, input logic [5:0] ma, input logic [7:0] op,
                     input logic bl32);
    wr(dlmc_pkg::OFF_CMD, {14'h0, 1'b1, bl32, k, ma, op});
  endtask : cmd
  task automatic mode_register_write_cmd(input logic [5:0] ma, input logic [7:0] op);
    cmd(dlmc_pkg::DLMC_MRW, ma, op, 1'b0);
    repeat (4) @(posedge i_clk);
    #1;
  endtask : mode_register_write_cmd
  task automatic mode_register_read_cmd(input logic [7:0] exp);
    cmd(dlmc_pkg::DLMC_MRR, dlmc_pkg::MA_LAT, 8'h00, 1'b0);
    repeat (2) @(posedge i_clk);
    rd(dlmc_pkg::OFF_STAT);
    cmp(d[7:0] & 8'h20, 8'h20);
    rd(dlmc_pkg::OFF_RDATA);
    cmp(d[7:0], exp);
    rd(dlmc_pkg::OFF_STAT);
    cmp(d[7:0] & 8'h20, 8'h00);
  endtask : mode_register_read_cmd
  // gap counts clocks from the cycle after the last beat to the precharge pulse
  task automatic burst(input logic [1:0] k, input logic bl32, input logic [7:0] col,
                       input logic [7:0] lat, input int gap);
    int m;
    m = 0;
    cmd(k, 6'h00, col, bl32);
    #1;
    while (!o_beat_valid && m < 100) begin
      @(posedge i_clk);
      #1;
      m++;
    end
    cmp(8'(m), lat);
    for (int i = 0; i < (bl32 ? 32 : 16); i++) begin
      cmp({o_beat_write, o_beat_valid, o_busy, o_beat_index}, {!k[0], 2'h3, 5'(i)});
      @(posedge i_clk);
      #1;
    end
    m = 0;
    while (!o_precharge && m < 100) begin
      @(posedge i_clk);
      #1;
      m++;
    end
    cmp(8'(m), 8'(gap));
    $display("burst done");
  endtask : burst
  task automatic t_reset();
    @(posedge i_clk);
    #1;
    cmp(8'(o_read_latency), 8'h06);
    cmp(8'(o_write_latency), 8'h04);
    cmp(8'(o_rtp_cycles), 8'h08);
    cmp(8'(o_wrec_cycles), 8'h06);
    cmp({7'h0, o_write_leveling}, 8'h00);
    $display("reset done");
  endtask : t_reset
  task automatic t_lat();
    for (int v = 0; v < 2; v++) begin
      mode_register_write_cmd(dlmc_pkg::MA_IO, 8'(v * 64));
      for (int c = 0; c < 8; c++) begin
        mode_register_write_cmd(dlmc_pkg::MA_LAT, 8'(c + v * 64 + c * 8));
        cmp(8'(o_read_latency), v ? RB[c] : RA[c]);
        cmp(8'(o_rtp_cycles), RTP[c]);
        cmp(8'(o_write_latency), v ? WB[c] : WA[c]);
      end
    end
    mode_register_write_cmd(dlmc_pkg::MA_IO, 8'h00);
    $display("latency done");
  endtask : t_lat
  task automatic t_setpt();
    mode_register_write_cmd(dlmc_pkg::MA_LAT, 8'h02);
    mode_register_write_cmd(dlmc_pkg::MA_SP, 8'h40);
    mode_register_write_cmd(dlmc_pkg::MA_LAT, 8'h3F);
    cmp(8'(o_read_latency), 8'h0E);
    mode_register_read_cmd(8'h3F);
    mode_register_write_cmd(dlmc_pkg::MA_SP, 8'hC0);
    cmp(8'(o_read_latency), 8'h24);
    cmp(8'(o_write_latency), 8'h12);
    mode_register_write_cmd(dlmc_pkg::MA_SP, 8'h00);
    mode_register_read_cmd(8'h02);
    cmp(8'(o_read_latency), 8'h0E);
    $display("set point done");
  endtask : t_setpt
  task automatic t_level();
    mode_register_write_cmd(dlmc_pkg::MA_LAT, 8'h81);
    cmp({7'h0, o_write_leveling}, 8'h01);
    mode_register_write_cmd(dlmc_pkg::MA_IO, 8'h40);
    rd(dlmc_pkg::OFF_STAT);
    cmp(d[7:0] & 8'h18, 8'h18);
    cmp(8'(o_read_latency), 8'h0A);
    wr(dlmc_pkg::OFF_STAT, 32'h0);
    rd(dlmc_pkg::OFF_STAT);
    cmp(d[7:0] & 8'h18, 8'h08);
    mode_register_write_cmd(dlmc_pkg::MA_LAT, 8'h01);
    cmp({7'h0, o_write_leveling}, 8'h00);
    $display("leveling done");
  endtask : t_level
  task automatic t_band();
    for (int i = 0; i < 8; i++) begin
      wr(dlmc_pkg::OFF_FREQ, {20'h0, TOP[i]});
      rd(dlmc_pkg::OFF_STAT);
      cmp({5'h0, d[2:0]}, 8'(i));
      cmp({2'h0, d[13:8]}, WRITE_RECOVERY_CYCLES[i]);
      if (i < 7) begin
        wr(dlmc_pkg::OFF_FREQ, {20'h0, TOP[i] + 12'h001});
        rd(dlmc_pkg::OFF_STAT);
        cmp({5'h0, d[2:0]}, 8'(i + 1));
      end
    end
    $display("band done");
  endtask : t_band
  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_lat();
    t_setpt();
    t_level();
    t_band();
    mode_register_write_cmd(dlmc_pkg::MA_LAT, 8'h00);
    burst(dlmc_pkg::DLMC_WRITE, 1'b0, 8'hFF, 8'h04, 6);
    burst(dlmc_pkg::DLMC_WRITE, 1'b1, 8'hFF, 8'h04, 6);
    burst(dlmc_pkg::DLMC_READ, 1'b1, 8'h00, 8'h06, 16);
    mode_register_write_cmd(dlmc_pkg::MA_WREC, 8'h70);
    cmp(8'(o_wrec_cycles), 8'h28);
    burst(dlmc_pkg::DLMC_WRITE, 1'b0, 8'h00, 8'h04, 40);
    end_of_test();
  end
endmodule : dram_latency_mode_config_test
